/* File: core/dss_buf.sv */
`timescale 1ns/1ps
module dss_buf #(
	parameter int NCH = dss_pkg::DSS_NCH
) (
	// clock and reset
	input  wire logic                           ref_clk,
	input  wire logic                           sys_rst,
	// incoming results
	dss_res_if.snk                              res,
	input  wire logic                           clr,
	// checks
	input  wire logic [dss_pkg::DSS_RES_W-1:0]  lo_lim,
	input  wire logic [dss_pkg::DSS_RES_W-1:0]  hi_lim,
	input  wire dss_pkg::dss_zc_t               zc_mode,
	// readback
	input  wire logic [dss_pkg::DSS_SLOT_W-1:0] rd_slot,
	output logic [dss_pkg::DSS_RES_W-1:0]       rd_data,
	output logic [NCH-1:0]                      lim_flags,
	output logic                                zc_flag
);
	import dss_pkg::*;

	function automatic logic zc_test(input dss_zc_t m,
		input logic [DSS_RES_W-1:0] p, input logic [DSS_RES_W-1:0] c);
		logic rise;
		logic fall;
		rise = (p < DSS_ZC_REF) && (c >= DSS_ZC_REF);
		fall = (p >= DSS_ZC_REF) && (c < DSS_ZC_REF);
		return ((m == DSS_ZC_RISE) && rise) || ((m == DSS_ZC_FALL) && fall)
			|| ((m == DSS_ZC_ANY) && (rise || fall));
	endfunction

	logic [DSS_RES_W-1:0] mem_q [NCH];
	logic [NCH-1:0]       seen_q;

	wire logic [DSS_RES_W-1:0] prev   = mem_q[res.slot];
	wire logic                 out_rng = (res.data < lo_lim)
		|| (res.data > hi_lim);
	wire logic                 zc_hit = res.wr && seen_q[res.slot]
		&& zc_test(zc_mode, prev, res.data);

	// ****************************************
	// result store, per-channel limit flags and zero-crossing flag
	// ****************************************
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			for (int i = 0; i < NCH; i++) begin
				mem_q[i] <= DSS_RES_RST;
			end
			seen_q    <= '0;
			lim_flags <= '0;
			zc_flag   <= 1'b0;
			rd_data   <= DSS_RES_RST;
		end else begin
			if (res.wr) begin
				mem_q[res.slot]  <= res.data;
				seen_q[res.slot] <= 1'b1;
			end
			// set after clear so a hit in the clear cycle survives
			if (clr) begin
				lim_flags <= '0;
				zc_flag   <= 1'b0;
			end
			if (res.wr && out_rng) begin
				lim_flags[res.chan] <= 1'b1;
			end
			if (zc_hit) begin
				zc_flag <= 1'b1;
			end
			rd_data <= mem_q[rd_slot];
		end
	end

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	store_word_a: assert property (
		res.wr |=> mem_q[$past(res.slot)] == $past(res.data))
		else $error("result not stored in its slot");

	limit_flag_a: assert property (
		(res.wr && out_rng) |=> lim_flags[$past(res.chan)])
		else $error("out of range result left no channel flag");

endmodule

/* File: core/dss_pkg.sv */
package dss_pkg;

	// ****************************************
	// sizes
	// ****************************************
	localparam int DSS_NCH          = 8;
	localparam int DSS_RES_W        = 12;
	localparam int DSS_CH_W         = 3;
	localparam int DSS_SLOT_W       = 3;
	// channel bit that routes a sequential sample to converter b
	localparam int DSS_CONV_SEL_BIT = 2;

	// ****************************************
	// modes and codes
	// ****************************************
	typedef enum logic [1:0] {
		DSS_MODE_ONCE = 2'h0,
		DSS_MODE_TRIG = 2'h1,
		DSS_MODE_LOOP = 2'h2
	} dss_mode_t;

	typedef enum logic [1:0] {
		DSS_ZC_OFF  = 2'h0,
		DSS_ZC_RISE = 2'h1,
		DSS_ZC_FALL = 2'h2,
		DSS_ZC_ANY  = 2'h3
	} dss_zc_t;

	// zero level of an offset-binary result
	localparam logic [DSS_RES_W-1:0] DSS_ZC_REF = 12'h800;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic [DSS_RES_W-1:0] DSS_RES_RST  = 12'h000;
	localparam logic [DSS_SLOT_W-1:0] DSS_SLOT_RST = 3'h0;

endpackage

/* File: core/dss_res_if.sv */
`timescale 1ns/1ps
interface dss_res_if;
	import dss_pkg::*;
	logic                  wr;
	logic [DSS_SLOT_W-1:0] slot;
	logic [DSS_CH_W-1:0]   chan;
	logic [DSS_RES_W-1:0]  data;
	modport src (output wr, output slot, output chan, output data);
	modport snk (input wr, input slot, input chan, input data);
endinterface

/* File: core/dss_seq.sv */
// Contract
// - eight inputs muxed to two sample paths, each with its 12-bit converter
// - each converter writes results into its own readable buffer
// - modes: one scan and stop, scan per trigger, or loop until stopped
// - sequential mode samples up to eight list entries in list order
// - sequential scans use either converter depending on the input sampled
// - simultaneous mode starts both paths together on two list entries; a lone last entry starts on converter a only
// - end of scan raises optional interrupt if any result beyond limits
// - optional interrupt on selectable zero-crossing conditions
`timescale 1ns/1ps
module dss_seq (
	// clock and reset
	input  wire logic                                    ref_clk,
	input  wire logic                                    sys_rst,
	// scan control
	input  wire logic                                    start,
	input  wire logic                                    stop,
	input  wire dss_pkg::dss_mode_t                      scan_mode,
	input  wire logic                                    simul,
	input  wire logic [dss_pkg::DSS_SLOT_W-1:0]          last_slot,
	input  wire logic [dss_pkg::DSS_NCH*dss_pkg::DSS_CH_W-1:0] chan_list,
	input  wire logic                                    trig_pin,
	// checks
	input  wire logic [dss_pkg::DSS_RES_W-1:0]           lo_lim,
	input  wire logic [dss_pkg::DSS_RES_W-1:0]           hi_lim,
	input  wire dss_pkg::dss_zc_t                        zc_mode,
	input  wire logic                                    lim_irq_en,
	input  wire logic                                    zc_irq_en,
	// converter a
	output logic                                         conv_a_start,
	output logic [dss_pkg::DSS_CH_W-1:0]                 conv_a_chan,
	input  wire logic                                    conv_a_done,
	input  wire logic [dss_pkg::DSS_RES_W-1:0]           conv_a_data,
	// converter b
	output logic                                         conv_b_start,
	output logic [dss_pkg::DSS_CH_W-1:0]                 conv_b_chan,
	input  wire logic                                    conv_b_done,
	input  wire logic [dss_pkg::DSS_RES_W-1:0]           conv_b_data,
	// readback and status
	input  wire logic [dss_pkg::DSS_SLOT_W-1:0]          rd_slot,
	output logic [dss_pkg::DSS_RES_W-1:0]                rd_a_data,
	output logic [dss_pkg::DSS_RES_W-1:0]                rd_b_data,
	output logic [dss_pkg::DSS_NCH-1:0]                  lim_flags,
	output logic                                         busy,
	output logic                                         scan_done,
	output logic                                         irq_lim,
	output logic                                         irq_zc
);
	import dss_pkg::*;

	typedef enum logic [4:0] {
		ST_IDLE   = 5'h01,
		ST_ARM    = 5'h02,
		ST_LAUNCH = 5'h04,
		ST_WAIT   = 5'h08,
		ST_DONE   = 5'h10
	} dss_state_t;

	function automatic logic [DSS_CH_W-1:0] list_chan(
		input logic [DSS_NCH*DSS_CH_W-1:0] l,
		input logic [DSS_SLOT_W-1:0] i);
		return l[i*DSS_CH_W +: DSS_CH_W];
	endfunction

	dss_state_t            st_q;
	dss_state_t            st_d;
	logic [DSS_SLOT_W-1:0] idx_q;
	logic [DSS_SLOT_W-1:0] a_slot_q;
	logic [DSS_SLOT_W-1:0] b_slot_q;
	logic                  a_pend_q;
	logic                  b_pend_q;
	logic                  stop_req_q;
	logic                  trig_s1_q;
	logic                  trig_s2_q;
	logic                  trig_s3_q;
	logic [DSS_NCH-1:0]    flags_a;
	logic [DSS_NCH-1:0]    flags_b;
	logic                  zc_a;
	logic                  zc_b;

	dss_res_if res_a ();
	dss_res_if res_b ();

	// ****************************************
	// step decode
	// ****************************************
	wire logic [DSS_SLOT_W-1:0] idx_p1   = DSS_SLOT_W'(idx_q + 1'b1);
	wire logic [DSS_CH_W-1:0]   chan_cur = list_chan(chan_list, idx_q);
	wire logic [DSS_CH_W-1:0]   chan_nxt = list_chan(chan_list, idx_p1);
	wire logic                  has_pair = idx_q < last_slot;
	wire logic                  seq_b    = chan_cur[DSS_CONV_SEL_BIT];
	wire logic                  launch_a = simul | ~seq_b;
	wire logic                  launch_b = simul ? has_pair : seq_b;
	wire logic                  a_left   = a_pend_q & ~conv_a_done;
	wire logic                  b_left   = b_pend_q & ~conv_b_done;
	wire logic                  step_done = (st_q == ST_WAIT)
		&& !a_left && !b_left;
	wire logic                  last_step = simul ? !has_pair
		|| (idx_p1 == last_slot) : (idx_q == last_slot);
	wire logic [DSS_SLOT_W-1:0] idx_next = simul
		? DSS_SLOT_W'(idx_q + 2'h2) : idx_p1;
	wire logic                  trig_rise = trig_s2_q & ~trig_s3_q;
	wire logic                  halt     = stop | stop_req_q;
	wire logic                  scan_clr = (st_q == ST_LAUNCH)
		&& (idx_q == DSS_SLOT_RST);

	// ****************************************
	// sequencer
	// ****************************************
	always_comb begin
		st_d = st_q;
		unique case (st_q)
			ST_IDLE: begin
				if (start) begin
					st_d = (scan_mode == DSS_MODE_TRIG) ? ST_ARM
						: ST_LAUNCH;
				end
			end
			ST_ARM: begin
				if (halt) begin
					st_d = ST_IDLE;
				end else if (trig_rise) begin
					st_d = ST_LAUNCH;
				end
			end
			ST_LAUNCH: begin
				st_d = ST_WAIT;
			end
			ST_WAIT: begin
				if (step_done) begin
					st_d = last_step ? ST_DONE : ST_LAUNCH;
				end
			end
			ST_DONE: begin
				if (halt) begin
					st_d = ST_IDLE;
				end else if (scan_mode == DSS_MODE_LOOP) begin
					st_d = ST_LAUNCH;
				end else if (scan_mode == DSS_MODE_TRIG) begin
					st_d = ST_ARM;
				end else begin
					st_d = ST_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_q       <= ST_IDLE;
			stop_req_q <= 1'b0;
			trig_s1_q  <= 1'b0;
			trig_s2_q  <= 1'b0;
			trig_s3_q  <= 1'b0;
		end else begin
			st_q       <= st_d;
			stop_req_q <= halt && (st_q != ST_IDLE) && (st_d != ST_IDLE);
			trig_s1_q  <= trig_pin;
			trig_s2_q  <= trig_s1_q;
			trig_s3_q  <= trig_s2_q;
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			idx_q <= DSS_SLOT_RST;
		end else if (step_done) begin
			idx_q <= idx_next;
		end else if (st_q != ST_LAUNCH && st_q != ST_WAIT) begin
			idx_q <= DSS_SLOT_RST;
		end
	end

	// ****************************************
	// converter launch
	// ****************************************
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			conv_a_start <= 1'b0;
			conv_b_start <= 1'b0;
			conv_a_chan  <= '0;
			conv_b_chan  <= '0;
			a_slot_q     <= DSS_SLOT_RST;
			b_slot_q     <= DSS_SLOT_RST;
			a_pend_q     <= 1'b0;
			b_pend_q     <= 1'b0;
		end else if (st_q == ST_LAUNCH) begin
			conv_a_start <= launch_a;
			conv_b_start <= launch_b;
			conv_a_chan  <= chan_cur;
			conv_b_chan  <= simul ? chan_nxt : chan_cur;
			a_slot_q     <= idx_q;
			b_slot_q     <= simul ? idx_p1 : idx_q;
			a_pend_q     <= launch_a;
			b_pend_q     <= launch_b;
		end else begin
			conv_a_start <= 1'b0;
			conv_b_start <= 1'b0;
			a_pend_q     <= a_left;
			b_pend_q     <= b_left;
		end
	end

	// ****************************************
	// result buffers
	// ****************************************
	assign res_a.wr   = a_pend_q & conv_a_done;
	assign res_a.slot = a_slot_q;
	assign res_a.chan = conv_a_chan;
	assign res_a.data = conv_a_data;
	assign res_b.wr   = b_pend_q & conv_b_done;
	assign res_b.slot = b_slot_q;
	assign res_b.chan = conv_b_chan;
	assign res_b.data = conv_b_data;

	dss_buf u_buf_a (
		.ref_clk   (ref_clk),   .sys_rst   (sys_rst),
		.res       (res_a),     .clr       (scan_clr),
		.lo_lim    (lo_lim),    .hi_lim    (hi_lim),
		.zc_mode   (zc_mode),   .rd_slot   (rd_slot),
		.rd_data   (rd_a_data), .lim_flags (flags_a),
		.zc_flag   (zc_a)
	);

	dss_buf u_buf_b (
		.ref_clk   (ref_clk),   .sys_rst   (sys_rst),
		.res       (res_b),     .clr       (scan_clr),
		.lo_lim    (lo_lim),    .hi_lim    (hi_lim),
		.zc_mode   (zc_mode),   .rd_slot   (rd_slot),
		.rd_data   (rd_b_data), .lim_flags (flags_b),
		.zc_flag   (zc_b)
	);

	assign lim_flags = flags_a | flags_b;
	assign busy      = (st_q != ST_IDLE);

	// ****************************************
	// end of scan events
	// ****************************************
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			scan_done <= 1'b0;
			irq_lim   <= 1'b0;
			irq_zc    <= 1'b0;
		end else begin
			scan_done <= (st_q == ST_DONE);
			irq_lim   <= (st_q == ST_DONE) && lim_irq_en
				&& (|lim_flags);
			irq_zc    <= (st_q == ST_DONE) && zc_irq_en
				&& (zc_a | zc_b);
		end
	end

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	sequence s_relaunch;
		(st_q == ST_LAUNCH) ##1 (conv_a_start || conv_b_start);
	endsequence
	sequence s_lim_end;
		(st_q == ST_DONE) && lim_irq_en && (|lim_flags) ##1 irq_lim;
	endsequence
	path_split_a: assert property (
		(conv_a_start && conv_b_start) |-> conv_a_chan != conv_b_chan)
		else $error("both paths started on one input");
	seq_route_a: assert property (
		(conv_b_start && !conv_a_start) |-> conv_b_chan[DSS_CONV_SEL_BIT])
		else $error("low input routed to converter b");
	once_halt_a: assert property (
		(st_q == ST_DONE && scan_mode == DSS_MODE_ONCE) |=> st_q == ST_IDLE)
		else $error("single scan did not stop");
	loop_again_a: assert property (
		(st_q == ST_DONE && scan_mode == DSS_MODE_LOOP && !halt)
		|=> s_relaunch)
		else $error("continuous scan did not restart");
	trig_hold_a: assert property (
		(st_q == ST_ARM && !trig_rise && !halt) |=> st_q == ST_ARM)
		else $error("triggered scan ran without a trigger");
	list_step_a: assert property (
		(step_done && !last_step) |=> s_relaunch)
		else $error("scan list not continued");
	lim_irq_a: assert property (
		(st_q == ST_DONE && lim_irq_en && (|lim_flags)) |-> s_lim_end)
		else $error("limit interrupt missing at scan end");
	zc_irq_a: assert property (
		irq_zc |-> $past(zc_irq_en) && ($past(st_q) == ST_DONE))
		else $error("zero crossing interrupt outside scan end");
	one_pulse_a: assert property (
		conv_a_start |=> !conv_a_start ##1 a_pend_q || !conv_a_start)
		else $error("converter a start longer than one cycle");
endmodule

/* File: dv/dss_conv_model.sv */
`timescale 1ns/1ps
module dss_conv_model (
	// clock
	input  wire logic                                             ref_clk,
	// launch
	input  wire logic                                             start,
	input  wire logic [dss_pkg::DSS_CH_W-1:0]                     chan,
	input  wire logic [dss_pkg::DSS_NCH*dss_pkg::DSS_RES_W-1:0]   volts,
	input  wire logic [4:0]                                       lat_max,
	// result
	output logic                                                  done,
	output logic [dss_pkg::DSS_RES_W-1:0]                         data = 12'h5A5
);
	import dss_pkg::*;
	// ********
	// converter
	// ********
	logic                 pend = 1'b0;
	int                   cnt;
	logic [DSS_RES_W-1:0] val;
	always @(posedge ref_clk) begin
		done <= 1'b0;
		// bus not held outside the result cycle
		data <= ~data;
		if (start) begin
			pend = 1'b1;
			cnt = $urandom_range(lat_max);
			val = volts[chan*DSS_RES_W +: DSS_RES_W];
		end
		if (pend) begin
			if (cnt == 0) begin
				done <= 1'b1;
				data <= val;
				pend = 1'b0;
			end else begin
				cnt = cnt - 1;
			end
		end
	end
endmodule

/* File: dv/dual_adc_scan_sequencer_tb_top.sv */
`timescale 1ns/1ps
module dual_adc_scan_sequencer_tb_top;
	import dss_pkg::*;
	// ********
	// signals
	// ********
	logic        ref_clk = 1'b0, sys_rst = 1'b1, start = 1'b0, stop = 1'b0;
	logic        simul = 1'b0, trig_pin = 1'b0;
	logic        lim_irq_en = 1'b0, zc_irq_en = 1'b0, exp_zc;
	logic        busy, scan_done, irq_lim, irq_zc;
	logic        conv_a_start, conv_a_done, conv_b_start, conv_b_done;
	dss_mode_t   scan_mode = DSS_MODE_ONCE;
	dss_zc_t     zc_mode = DSS_ZC_OFF;
	logic [2:0]  last_slot = 3'h0, rd_slot = 3'h0, conv_a_chan, conv_b_chan;
	logic [23:0] chan_list = 24'h0;
	logic [11:0] lo_lim = 12'h000, hi_lim = 12'hFFF;
	logic [11:0] conv_a_data, conv_b_data, rd_a_data, rd_b_data;
	logic [11:0] exp_a [8] = '{default: DSS_RES_RST};
	logic [11:0] exp_b [8] = '{default: DSS_RES_RST};
	logic        ok_a [8] = '{default: 1'b0};
	logic        ok_b [8] = '{default: 1'b0};
	logic [95:0] volts = 96'h0;
	logic [7:0]  lim_flags, exp_flags = 8'h00;
	logic [4:0]  lat = 5'h00;
	int          n_fail, cmp_count, n_start, n_pair;

	dss_seq dut (.ref_clk, .sys_rst, .start, .stop, .scan_mode, .simul,
		.last_slot, .chan_list, .trig_pin, .lo_lim, .hi_lim, .zc_mode,
		.lim_irq_en, .zc_irq_en, .conv_a_start, .conv_a_chan, .conv_a_done,
		.conv_a_data, .conv_b_start, .conv_b_chan, .conv_b_done,
		.conv_b_data, .rd_slot, .rd_a_data, .rd_b_data, .lim_flags, .busy,
		.scan_done, .irq_lim, .irq_zc);
	dss_conv_model conv_a (.ref_clk, .start(conv_a_start), .chan(conv_a_chan),
		.volts, .lat_max(lat), .done(conv_a_done), .data(conv_a_data));
	dss_conv_model conv_b (.ref_clk, .start(conv_b_start), .chan(conv_b_chan),
		.volts, .lat_max(lat), .done(conv_b_done), .data(conv_b_data));

	initial forever #25 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		n_start += conv_a_start + conv_b_start;
		n_pair += conv_a_start & conv_b_start;
	end
	// ********
	// tasks
	// ********
	task automatic chk(input logic [11:0] got, exp, input string m);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, exp, input string m);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: %s got %b", $time, m, got);
		end
	endtask
	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	function automatic logic zc_hit(input logic [11:0] p, v);
		logic up;
		logic dn;
		up = p < DSS_ZC_REF && v >= DSS_ZC_REF;
		dn = p >= DSS_ZC_REF && v < DSS_ZC_REF;
		return (zc_mode == DSS_ZC_RISE && up) || (zc_mode == DSS_ZC_FALL && dn)
			|| (zc_mode == DSS_ZC_ANY && (up || dn));
	endfunction
	function automatic void predict();
		logic [2:0]  c;
		logic [11:0] v;
		logic        b;
		exp_flags = 8'h00;
		exp_zc = 1'b0;
		for (int i = 0; i <= last_slot; i++) begin
			c = chan_list[i*3 +: 3];
			v = volts[c*12 +: 12];
			b = simul ? i[0] : c[DSS_CONV_SEL_BIT];
			if (b ? ok_b[i] : ok_a[i]) begin
				exp_zc |= zc_hit(b ? exp_b[i] : exp_a[i], v);
			end
			if (v < lo_lim || v > hi_lim) exp_flags[c] = 1'b1;
			if (b) begin
				exp_b[i] = v;
				ok_b[i] = 1'b1;
			end else begin
				exp_a[i] = v;
				ok_a[i] = 1'b1;
			end
		end
	endfunction
	task automatic wait_done();
		int n;
		n = 0;
		do begin
			@(posedge ref_clk);
			#1;
			n++;
		end while (scan_done !== 1'b1 && n < 3000);
		predict();
		chk_bit(scan_done, 1'b1, "scan end");
		chk_bit(irq_lim, lim_irq_en & |exp_flags, "limit irq");
		chk_bit(irq_zc, zc_irq_en & exp_zc, "zero irq");
	endtask
	task automatic check_bufs();
		for (int s = 0; s < 8; s++) begin
			@(posedge ref_clk);
			rd_slot <= 3'(s);
			repeat (2) @(posedge ref_clk);
			#1;
			chk(rd_a_data, exp_a[s], "buffer a");
			chk(rd_b_data, exp_b[s], "buffer b");
		end
		chk({4'h0, lim_flags}, {4'h0, exp_flags}, "flags");
	endtask
	task automatic run(input int m, sm, ls, n);
		logic [23:0] l;
		logic [11:0] v;
		logic [95:0] vv;
		int          s0, p0, w;
		l = 24'($urandom);
		for (int i = 0; sm && i < 8; i += 2) begin
			if (l[i*3 +: 3] == l[i*3+3 +: 3]) l[i*3 +: 3] ^= 3'h1;
		end
		for (int c = 0; c < 8; c++) begin
			v = 12'($urandom);
			if (v[11:4] == 8'h7F || v[11:4] == 8'h80) v ^= 12'h400;
			vv[c*12 +: 12] = v;
		end
		if (m != DSS_MODE_TRIG && m != DSS_MODE_LOOP) n = 1;
		s0 = n_start;
		p0 = n_pair;
		@(posedge ref_clk);
		volts <= vv;
		chan_list <= l;
		scan_mode <= dss_mode_t'(m);
		simul <= sm[0];
		last_slot <= ls[2:0];
		lo_lim <= 12'($urandom_range(12'h600));
		hi_lim <= 12'($urandom_range(12'hFFF, 12'hA00));
		zc_mode <= dss_zc_t'($urandom_range(3));
		lim_irq_en <= 1'($urandom);
		zc_irq_en <= 1'($urandom);
		lat <= 5'($urandom_range(20));
		start <= 1'b1;
		@(posedge ref_clk);
		start <= 1'b0;
		if (m != DSS_MODE_LOOP) begin
			repeat (2) @(posedge ref_clk);
			// second start lands while busy
			start <= 1'b1;
			@(posedge ref_clk);
			start <= 1'b0;
		end
		for (int j = 0; j < n; j++) begin
			if (m == DSS_MODE_TRIG) begin
				w = n_start;
				repeat (6) @(posedge ref_clk);
				#1;
				chk_bit(n_start == w, 1'b1, "early launch");
				@(posedge ref_clk);
				trig_pin <= 1'b1;
				repeat (2) @(posedge ref_clk);
				trig_pin <= 1'b0;
			end
			if (m == DSS_MODE_LOOP && j == n - 1) begin
				w = 0;
				do begin
					@(posedge ref_clk);
					#1;
					w++;
				end while (!(conv_a_start | conv_b_start) && w < 50);
				@(posedge ref_clk);
				stop <= 1'b1;
				@(posedge ref_clk);
				stop <= 1'b0;
			end
			wait_done();
		end
		if (m == DSS_MODE_TRIG) begin
			repeat (3) @(posedge ref_clk);
			stop <= 1'b1;
			@(posedge ref_clk);
			stop <= 1'b0;
		end
		repeat (8) @(posedge ref_clk);
		#1;
		chk_bit(busy, 1'b0, "idle");
		chk(12'(n_start - s0), 12'(n * (ls + 1)), "launches");
		chk(12'(n_pair - p0), 12'(sm ? n * ((ls + 1) / 2) : 0), "pairs");
		check_bufs();
	endtask
	// ********
	// sequence
	// ********
	initial begin
		#2000000;
		n_fail++;
		$display("wrong value at %0t: run hung", $time);
		tally_and_finish();
	end
	initial begin
		void'($urandom(32'h9D6C4891));
		repeat (20) @(posedge ref_clk);
		sys_rst <= 1'b0;
		@(posedge ref_clk);
		#1;
		chk_bit(busy, 1'b0, "reset");
		check_bufs();
		for (int m = 0; m < 4; m++) begin
			run(m, 0, 7, 2);
			run(m, 1, 0, 2);
		end
		for (int k = 0; k < 12; k++) begin
			run($urandom_range(3), $urandom_range(1), $urandom_range(7),
				1 + $urandom_range(2));
		end
		tally_and_finish();
	end
endmodule
